// ---- rtl/ssf_cmd.sv ----
// servo setup command interpreter with wishbone registers, gain sets and input debounce
//
// Overview of operation
// - code 148 loads seven gains in order
// - gains limited to 0 through 32767
// - code 70 loads eight gains, split acceleration
// - second acceleration gain feeds extra damping
// - standard velocity filters ignore second acceleration gain
// - code 171 stops driving done on line 1
// - done indication disabled after reset
// - code 252 selector zero writes all filters
// - selector one to seven writes one filter
// - filter constant counted in 120 us ticks
// - up/down counter qualifies input state changes
// - filter constants reset to 83 ticks
// - code 184 mode sets rotation direction
// - direction after closed loop raises sequence fault
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssf_cmd
  import ssf_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 NRST,
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [7:0]           WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  input  wire logic [NUM_LINES-1:0] DIN,
  input  wire logic                 SERVO_BUSY,
  output logic      [NUM_LINES-1:0] DIN_FILT,
  output logic                      DONE_O,
  output logic                      DONE_OE,
  output logic                      DIR_REVERSE,
  output logic                      CLOSED_LOOP,
  output logic                      SEQ_FAULT,
  output ssf_gains_t                GAINS,
  output logic                      CMD_ACK,
  output logic                      IRQ
);

  // register words by byte address; gains and filter constants are read only,
  // so a stray write can never slip past the range checks of the commands
  //   0x00 command code in the low byte, parameter words staged beforehand
  //   0x04 control: done enable, closed loop (set only), standard filters
  //   0x08 event status, write one to clear; 0x0C mask of the same layout
  //   0x10 state: inputs, direction, loop, done, fault, filters, idle
  //   0x20 parameter words, 0x40 gains, 0x60 filter constants

  // whole register state of the block
  typedef struct packed {
    logic                             ack;
    logic [31:0]                      rdata;
    logic [NUM_PARAMS-1:0][15:0]      param;
    logic [NUM_PARAMS-1:0][15:0]      gain;
    logic [NUM_LINES-1:0][15:0]       filt;
    ssf_gains_t                       gout;
    logic                             done_en;
    logic                             closed;
    logic                             std_filt;
    logic                             dir_rev;
    logic                             fault;
    logic [NUM_EV-1:0]                ev_stat;
    logic [NUM_EV-1:0]                ev_mask;
    logic                             irq;
    logic                             cmd_ack;
    logic [NUM_LINES-1:0]             din_s1;
    logic [NUM_LINES-1:0]             din_s2;
    logic                             busy_s1;
    logic                             busy_s2;
    logic                             done_o;
    logic [NUM_LINES-1:0]             filt_prev;
  } ssf_top_state_t;

  ssf_top_state_t       s_q;
  ssf_top_state_t       s_d;
  logic                 tick;
  logic [NUM_LINES-1:0] filt_lvl;
  logic                 req;
  logic                 wr;
  logic [5:0]           idx;
  logic [2:0]           grp;
  logic [2:0]           off;
  logic [NUM_EV-1:0]    ev;
  logic [NUM_EV-1:0]    clr;
  logic [7:0]           opcode;
  logic                 gains_ok;
  logic [31:0]          rd;

  // merge a 16-bit register with the enabled byte lanes of a write
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  // one shared tick for all lines
  ssf_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .tick  (tick)
  );

  // per-line debounce filters read the second synchroniser stage
  // the first stage may still be settling, so nothing else reads it
  for (genvar gi = 0; gi < NUM_LINES; gi++) begin : g_filt
    ssf_filter u_filt (
      .clk    (CORE_CLK),
      .rst_n  (NRST),
      .tick   (tick),
      .sample (s_q.din_s2[gi]),
      .limit  (s_q.filt[gi]),
      .level  (filt_lvl[gi])
    );
  end

  // bus decode: ack one cycle after the request, dropped the cycle after
  // ack itself blocks a second take while stb still stands in the answer cycle
  assign req    = WB_CYC_I & WB_STB_I & ~s_q.ack;
  assign wr     = req & WB_WE_I;
  assign idx    = WB_ADR_I[7:2];
  assign grp    = idx[5:3];
  assign off    = idx[2:0];
  assign opcode = WB_DAT_I[7:0];

  // every gain of a set must sit inside the unsigned 15-bit range
  // a seven-gain set never checks the eighth word, which it does not use
  always_comb begin
    gains_ok = 1'b1;
    for (int i = 0; i < NUM_PARAMS; i++) begin
      if ((i < NUM_PARAMS - 1 || opcode == OP_LOAD_EXT_GAIN_SET) && s_q.param[i] > VALUE_MAX) begin
        gains_ok = 1'b0;
      end
    end
  end

  // read mux; unmapped words read as zero and still acknowledge
  // read data is registered with the ack and holds until the next request
  always_comb begin
    rd = '0;
    if (grp == GRP_MISC) begin
      case (idx)
        IDX_CTRL: begin
          rd[CTRL_DONE_EN]  = s_q.done_en;
          rd[CTRL_CLOSED]   = s_q.closed;
          rd[CTRL_STD_FILT] = s_q.std_filt;
        end
        IDX_IRQ_STAT: rd[NUM_EV-1:0] = s_q.ev_stat;
        IDX_IRQ_MASK: rd[NUM_EV-1:0] = s_q.ev_mask;
        IDX_STATE: begin
          rd[ST_DIN_LSB +: NUM_LINES] = filt_lvl;
          rd[ST_REV]     = s_q.dir_rev;
          rd[ST_CLOSED]  = s_q.closed;
          rd[ST_DONE_EN] = s_q.done_en;
          rd[ST_FAULT]   = s_q.fault;
          rd[ST_STD]     = s_q.std_filt;
          rd[ST_IDLE]    = ~s_q.busy_s2;
        end
        default: rd = '0;
      endcase
    end else if (grp == GRP_PARAM) begin
      rd[15:0] = s_q.param[off];
    end else if (grp == GRP_GAIN) begin
      rd[15:0] = s_q.gain[off];
    end else if (grp == GRP_FILT && off < 3'(NUM_LINES)) begin
      rd[15:0] = s_q.filt[off];
    end
  end

  // next state: synchronisers, bus writes, command execution, events
  always_comb begin
    s_d = s_q;
    ev  = '0;
    clr = '0;
    s_d.cmd_ack = 1'b0;
    s_d.din_s1  = DIN;
    s_d.din_s2  = s_q.din_s1;
    s_d.busy_s1 = SERVO_BUSY;
    s_d.busy_s2 = s_q.busy_s1;
    s_d.ack     = req;
    if (req) begin
      s_d.rdata = rd;
    end

    // plain register writes
    if (wr && grp == GRP_MISC) begin
      case (idx)
        IDX_CTRL: begin
          if (WB_SEL_I[0]) begin
            s_d.done_en  = WB_DAT_I[CTRL_DONE_EN];
            s_d.closed   = s_q.closed | WB_DAT_I[CTRL_CLOSED];  // set only, only reset clears it
            s_d.std_filt = WB_DAT_I[CTRL_STD_FILT];
          end
        end
        IDX_IRQ_STAT: begin
          if (WB_SEL_I[0]) begin
            clr = WB_DAT_I[NUM_EV-1:0];
          end
        end
        IDX_IRQ_MASK: begin
          if (WB_SEL_I[0]) begin
            s_d.ev_mask = WB_DAT_I[NUM_EV-1:0];
          end
        end
        default: s_d.ev_mask = s_q.ev_mask;
      endcase
    end else if (wr && grp == GRP_PARAM) begin
      s_d.param[off] = merge16(s_q.param[off], WB_DAT_I, WB_SEL_I);
    end

    // command word: code in the low byte, parameters already in the param words
    if (wr && idx == IDX_CMD && WB_SEL_I[0]) begin
      case (opcode)
        // a refused set leaves every gain as it was, never half loaded
        OP_LOAD_GAIN_SET: begin
          if (gains_ok) begin
            s_d.gain[G_KV1]  = s_q.param[0];
            s_d.gain[G_KV2]  = s_q.param[1];
            s_d.gain[G_KVFF] = s_q.param[2];
            s_d.gain[G_KA1]  = s_q.param[3];
            s_d.gain[G_KA2]  = '0;  // single acceleration term leaves no second one
            s_d.gain[G_KAFF] = s_q.param[4];
            s_d.gain[G_KP]   = s_q.param[5];
            s_d.gain[G_KI]   = s_q.param[6];
            ev[EV_ACK] = 1'b1;
          end else begin
            ev[EV_CMD_ERR] = 1'b1;
          end
        end
        OP_LOAD_EXT_GAIN_SET: begin
          if (gains_ok) begin
            s_d.gain = s_q.param;  // same slot order as the eight parameters
            ev[EV_ACK] = 1'b1;
          end else begin
            ev[EV_CMD_ERR] = 1'b1;
          end
        end
        OP_DONE_OUTPUT_DIS: begin
          s_d.done_en = 1'b0;
          ev[EV_ACK] = 1'b1;
        end
        // a bad selector or constant changes no line at all
        OP_INPUT_DEBOUNCE: begin
          if (s_q.param[1] > VALUE_MAX || s_q.param[0] > LINE_MAX) begin
            ev[EV_CMD_ERR] = 1'b1;
          end else if (s_q.param[0] == SEL_ALL) begin
            for (int i = 0; i < NUM_LINES; i++) begin
              s_d.filt[i] = s_q.param[1];
            end
            ev[EV_ACK] = 1'b1;
          end else begin
            s_d.filt[s_q.param[0][2:0] - 3'h1] = s_q.param[1];
            ev[EV_ACK] = 1'b1;
          end
        end
        // direction locks once the loop is closed; a late attempt is a fault
        OP_DIRECTION: begin
          if (s_q.closed) begin
            ev[EV_SEQ_ERR] = 1'b1;
            s_d.fault = 1'b1;
          end else if (s_q.param[0] == DIR_CW) begin
            s_d.dir_rev = 1'b0;
            ev[EV_ACK] = 1'b1;
          end else if (s_q.param[0] == DIR_CCW) begin
            s_d.dir_rev = 1'b1;
            ev[EV_ACK] = 1'b1;
          end else begin
            ev[EV_CMD_ERR] = 1'b1;
          end
        end
        default: ev[EV_CMD_ERR] = 1'b1;
      endcase
    end

    // acknowledgement carries no payload, only the pulse and status bit
    s_d.cmd_ack = ev[EV_ACK];

    // any qualified input change is an event
    // both sides reset low, so leaving reset raises no false change
    ev[EV_IN_CHG] = |(filt_lvl ^ s_q.filt_prev);
    s_d.filt_prev = filt_lvl;

    // sticky status: a new event beats a clear in the same cycle
    s_d.ev_stat = (s_q.ev_stat & ~clr) | ev;
    s_d.irq     = |(s_d.ev_stat & s_d.ev_mask);

    // gains to the loop; second accel term only outside standard filters
    s_d.gout.velocity_first_gain  = s_d.gain[G_KV1];
    s_d.gout.velocity_second_gain = s_d.gain[G_KV2];
    s_d.gout.velocity_ff_gain     = s_d.gain[G_KVFF];
    s_d.gout.accel_first_gain     = s_d.gain[G_KA1];
    s_d.gout.accel_second_gain    = s_d.std_filt ? '0 : s_d.gain[G_KA2];
    s_d.gout.accel_ff_gain        = s_d.gain[G_KAFF];
    s_d.gout.proportional_gain    = s_d.gain[G_KP];
    s_d.gout.integrator_gain      = s_d.gain[G_KI];

    // done reads high while idle, and is only driven when enabled
    // the synchroniser makes done lag the busy pin by two clocks
    s_d.done_o = ~s_d.busy_s2;
  end

  // single state register; filters and done enable take their reset values here
  // a mid-run reset also reopens the direction lock and clears the fault
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q         <= '0;  // done disabled, clockwise, open loop
      s_q.filt    <= {NUM_LINES{FILT_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  // all outputs are flip-flop outputs
  assign WB_DAT_O    = s_q.rdata;
  assign WB_ACK_O    = s_q.ack;
  assign DIN_FILT    = filt_lvl;
  assign DONE_O      = s_q.done_o;
  assign DONE_OE     = s_q.done_en;
  assign DIR_REVERSE = s_q.dir_rev;
  assign CLOSED_LOOP = s_q.closed;
  assign SEQ_FAULT   = s_q.fault;
  assign GAINS       = s_q.gout;
  assign CMD_ACK     = s_q.cmd_ack;
  assign IRQ         = s_q.irq;

endmodule
`default_nettype wire

// ---- rtl/ssf_pkg.sv ----
// shared constants, opcodes, register map and types for the servo setup command block
package ssf_pkg;

  // timing: tick length in microseconds and the core clock rate
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned TICK_US         = 120;
  localparam int unsigned TICK_CYCLES_DEF = TICK_US * CLK_MHZ;

  // sizes
  localparam int NUM_LINES  = 7;
  localparam int NUM_PARAMS = 8;
  localparam int NUM_EV     = 4;

  // command codes
  localparam logic [7:0] OP_LOAD_GAIN_SET     = 8'h94;  // 148
  localparam logic [7:0] OP_LOAD_EXT_GAIN_SET = 8'h46;  // 70
  localparam logic [7:0] OP_DONE_OUTPUT_DIS   = 8'hAB;  // 171
  localparam logic [7:0] OP_INPUT_DEBOUNCE    = 8'hFC;  // 252
  localparam logic [7:0] OP_DIRECTION         = 8'hB8;  // 184

  // parameter values and limits
  localparam logic [15:0] VALUE_MAX    = 16'h7FFF;  // 32767
  localparam logic [15:0] FILT_RESET   = 16'h0053;  // 83 ticks
  localparam logic [15:0] DIR_CW       = 16'h0000;
  localparam logic [15:0] DIR_CCW      = 16'h0001;
  localparam logic [15:0] SEL_ALL      = 16'h0000;
  localparam logic [15:0] LINE_MAX     = 16'h0007;

  // register word indices (byte address = 4 * index); groups of eight above index 7
  localparam logic [5:0] IDX_CMD      = 6'h00;
  localparam logic [5:0] IDX_CTRL     = 6'h01;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h02;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h03;
  localparam logic [5:0] IDX_STATE    = 6'h04;
  localparam logic [2:0] GRP_MISC     = 3'h0;
  localparam logic [2:0] GRP_PARAM    = 3'h1;  // 0x20..0x3C
  localparam logic [2:0] GRP_GAIN     = 3'h2;  // 0x40..0x5C
  localparam logic [2:0] GRP_FILT     = 3'h3;  // 0x60..0x78

  // control register bits
  localparam int CTRL_DONE_EN  = 0;
  localparam int CTRL_CLOSED   = 1;
  localparam int CTRL_STD_FILT = 2;

  // event bits in status and mask
  localparam int EV_ACK     = 0;
  localparam int EV_CMD_ERR = 1;
  localparam int EV_SEQ_ERR = 2;
  localparam int EV_IN_CHG  = 3;

  // state register fields
  localparam int ST_DIN_LSB = 0;
  localparam int ST_REV     = 8;
  localparam int ST_CLOSED  = 9;
  localparam int ST_DONE_EN = 10;
  localparam int ST_FAULT   = 11;
  localparam int ST_STD     = 12;
  localparam int ST_IDLE    = 13;

  // gain slots, in load order
  localparam int G_KV1  = 0;
  localparam int G_KV2  = 1;
  localparam int G_KVFF = 2;
  localparam int G_KA1  = 3;
  localparam int G_KA2  = 4;
  localparam int G_KAFF = 5;
  localparam int G_KP   = 6;
  localparam int G_KI   = 7;

  // gains as handed to the servo loop
  typedef struct packed {
    logic [15:0] velocity_first_gain;
    logic [15:0] velocity_second_gain;
    logic [15:0] velocity_ff_gain;
    logic [15:0] accel_first_gain;
    logic [15:0] accel_second_gain;
    logic [15:0] accel_ff_gain;
    logic [15:0] proportional_gain;
    logic [15:0] integrator_gain;
  } ssf_gains_t;

endpackage

// ---- rtl/ssf_tick.sv ----
// free running tick generator for the input filters
`timescale 1ns/1ps
`default_nettype none
module ssf_tick
  import ssf_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } ssf_tick_state_t;

  ssf_tick_state_t s_q;
  ssf_tick_state_t s_d;

  // one pulse every CYCLES clocks
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 32'(CYCLES - 1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule
`default_nettype wire

// ---- rtl/ssf_filter.sv ----
// up/down counting debounce filter for one digital input line
`timescale 1ns/1ps
`default_nettype none
module ssf_filter (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        sample,
  input  wire logic [15:0] limit,
  output logic             level
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        level;
  } ssf_filt_state_t;

  ssf_filt_state_t s_q;
  ssf_filt_state_t s_d;

  // candidate ticks count up, old-state ticks count down, so bounce only delays
  always_comb begin
    s_d = s_q;
    if (limit == 16'h0000) begin
      s_d.level = sample;  // no qualifying delay
      s_d.cnt   = '0;
    end else if (tick) begin
      if (sample != s_q.level) begin
        if (s_q.cnt + 16'h0001 >= limit) begin
          s_d.level = sample;
          s_d.cnt   = '0;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else if (s_q.cnt != 16'h0000) begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;

endmodule
`default_nettype wire

// ---- bench/ssf_cmd_asserts.sv ----
// port-level assertion checker for the servo setup command block
`timescale 1ns/1ps
`default_nettype none
module ssf_cmd_asserts
  import ssf_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic        DONE_OE,
  input wire logic        DIR_REVERSE,
  input wire logic        CLOSED_LOOP,
  input wire logic        SEQ_FAULT,
  input wire ssf_gains_t  GAINS,
  input wire logic        CMD_ACK
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  // a take needs ack low, so the answer cycle never counts as a new request
  logic take;
  logic ctrl_on;
  assign take    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign ctrl_on = take & WB_WE_I & (WB_ADR_I[7:2] == IDX_CTRL) & WB_DAT_I[CTRL_DONE_EN];

  AST_ACK_NEXT: assert property (take |=> WB_ACK_O)
    else $error("bus request not answered one cycle later");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack held longer than one cycle");
  AST_CMD_ACK_WITH_BUS: assert property (CMD_ACK |-> WB_ACK_O ##1 !CMD_ACK)
    else $error("command ack not a single pulse with the bus ack");
  AST_DONE_OE_CAUSE: assert property ($rose(DONE_OE) |-> $past(ctrl_on) || $past(ctrl_on, 2))
    else $error("done output enabled without an enabling write");
  AST_DIR_LOCKED: assert property ($past(CLOSED_LOOP) |-> $stable(DIR_REVERSE))
    else $error("direction changed in closed loop");
  AST_CLOSED_STICKY: assert property (CLOSED_LOOP |=> CLOSED_LOOP)
    else $error("closed loop dropped without reset");
  AST_FAULT_CAUSE: assert property ($rose(SEQ_FAULT) |-> $past(CLOSED_LOOP))
    else $error("sequence fault raised outside closed loop");
  AST_FAULT_STICKY: assert property (SEQ_FAULT |=> SEQ_FAULT)
    else $error("sequence fault cleared without reset");
  AST_GAIN_RANGE: assert property (!(GAINS[127] | GAINS[111] | GAINS[95] | GAINS[79] |
                                     GAINS[63] | GAINS[47] | GAINS[31] | GAINS[15]))
    else $error("gain above 32767 reached the loop");

  // main scenarios seen at least once
  cover property (CMD_ACK);
  cover property ($rose(SEQ_FAULT));
  cover property ($rose(DONE_OE));
endmodule

bind ssf_cmd ssf_cmd_asserts i_chk (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .DONE_OE(DONE_OE), .DIR_REVERSE(DIR_REVERSE), .CLOSED_LOOP(CLOSED_LOOP),
  .SEQ_FAULT(SEQ_FAULT), .GAINS(GAINS), .CMD_ACK(CMD_ACK)
);
`default_nettype wire

// ---- bench/ssf_host.sv ----
// host model that stages parameters and issues commands over the register bus
`timescale 1ns/1ps
`default_nettype none
module ssf_host (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  localparam int NUM_PARAMS_H = 8;

  // bus idle at time zero; both byte lanes always enabled
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h3;
    wdat = 32'h0000_0000;
  end

  // one classic cycle: held until ack is sampled, data taken at that edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= ~a;  // released lines never keep the last value
    wdat <= ~d;
  endtask

  // eight parameter words, first one in the top slice, then the code
  task automatic cmd(input logic [7:0] op, input logic [127:0] p);
    logic [31:0] r;
    for (int k = 0; k < NUM_PARAMS_H; k++) begin
      acc(1'b1, 8'h20 + 8'(4 * k), {16'h0000, p[127 - 16 * k -: 16]}, r);
    end
    acc(1'b1, 8'h00, {24'h00_0000, op}, r);
  endtask

  // default proportional gain rescaled to the encoder resolution
  function automatic logic [15:0] kp_scaled(input logic [15:0] kp, input int cpr);
    return 16'(int'(kp) * cpr / 4000);
  endfunction
endmodule
`default_nettype wire

// ---- bench/ssf_cmd_tb.sv ----
// self-checking bench for the servo setup command block
`timescale 1ns/1ps
`default_nettype none
module ssf_cmd_tb
  import ssf_pkg::*;
;
  localparam int TC = 16;  // short tick keeps the debounce walk brief
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [NUM_LINES-1:0] din = '0;
  logic                 busy = 1'b0;
  logic                 cyc, stb, we, ack, done, done_oe, dir, closed, fault, cack, irq;
  logic [7:0]           adr;
  logic [3:0]           sel;
  logic [31:0]          wdat, rdat, v;
  logic [NUM_LINES-1:0] filt;
  logic [15:0]          kp;
  ssf_gains_t           gains, g;
  int                   fail_count = 0;
  int                   checked = 0;
  int                   n_ack = 0;

  always #2.5 clk = ~clk;

  // command acknowledgement pulses, tallied against the accepted commands
  always @(posedge clk) begin
    if (cack === 1'b1) begin
      n_ack++;
    end
  end

  ssf_cmd #(.TICK_CYCLES(TC)) i_dut (
    .CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .DIN(din), .SERVO_BUSY(busy), .DIN_FILT(filt), .DONE_O(done), .DONE_OE(done_oe),
    .DIR_REVERSE(dir), .CLOSED_LOOP(closed), .SEQ_FAULT(fault), .GAINS(gains),
    .CMD_ACK(cack), .IRQ(irq)
  );

  ssf_host i_host (
    .clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .wdat(wdat)
  );

  // comparisons: plain words and the whole gain set
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_g(input string n, input ssf_gains_t e);
    checked++;
    if (gains !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, gains);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    i_host.acc(1'b0, a, 32'h0000_0000, v);
    chk($sformatf("reg %h", a), e, v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.acc(1'b1, a, d, v);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a full run needs about 720 cycles; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    report_and_stop;
  end

  initial begin
    idle(16);
    nrst <= 1'b1;
    idle(4);
    chk("done_oe", 32'h0000_0000, done_oe);
    chk("done idle", 32'h0000_0001, done);
    chk("dir", 32'h0000_0000, dir);
    for (int k = 0; k < NUM_LINES; k++) begin
      rchk(8'h60 + 8'(4 * k), 32'h0000_0053);
    end
    rchk(8'hFC, 32'h0000_0000);
    // seven-gain set with a top-range value, then a refused one
    kp = i_host.kp_scaled(16'h00C8, 8000);
    i_host.cmd(OP_LOAD_GAIN_SET, {16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, kp, 16'h7FFF, 16'h0000});
    g = {16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0000, 16'h0005, kp, 16'h7FFF};
    chk_g("gain set", g);
    wr(8'h08, 32'h0000_000F);
    i_host.cmd(OP_LOAD_GAIN_SET, {16'h0001, 16'h0002, 16'h0003, 16'h8000, 64'h0});
    chk_g("refused set", g);
    rchk(8'h08, 32'h0000_0002);
    chk("irq masked", 32'h0000_0000, irq);
    // eight-gain set, then standard filters hide the second accel gain
    g = {16'h0011, 16'h0012, 16'h0013, 16'h0014, 16'h0015, 16'h0016, 16'h0017, 16'h7FFF};
    i_host.cmd(OP_LOAD_EXT_GAIN_SET, g);
    chk_g("ext set", g);
    wr(8'h04, 32'h0000_0004);
    idle(2);
    g.accel_second_gain = 16'h0000;
    chk_g("std filters", g);
    wr(8'h04, 32'h0000_0001);
    idle(2);
    chk("done_oe on", 32'h0000_0001, done_oe);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h08, 32'h0000_000F);
    i_host.cmd(OP_DONE_OUTPUT_DIS, 128'h0);
    idle(2);
    chk("done_oe off", 32'h0000_0000, done_oe);
    chk("irq ack", 32'h0000_0001, irq);
    rchk(8'h08, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    idle(1);
    chk("irq cleared", 32'h0000_0000, irq);
    busy <= 1'b1;
    idle(6);
    chk("done busy", 32'h0000_0000, done);
    // filter constants: all lines, one line, then a bad selector
    i_host.cmd(OP_INPUT_DEBOUNCE, {16'h0000, 16'h0009, 96'h0});
    for (int k = 0; k < NUM_LINES; k++) begin
      rchk(8'h60 + 8'(4 * k), 32'h0000_0009);
    end
    i_host.cmd(OP_INPUT_DEBOUNCE, {16'h0003, 16'h0000, 96'h0});
    for (int k = 0; k < NUM_LINES; k++) begin
      rchk(8'h60 + 8'(4 * k), (k == 2) ? 32'h0000_0000 : 32'h0000_0009);
    end
    din <= 7'h04;
    idle(6);
    chk("pass through", 32'h0000_0004, filt);
    din <= 7'h00;
    idle(6);
    wr(8'h08, 32'h0000_000F);
    i_host.cmd(OP_INPUT_DEBOUNCE, {16'h0008, 16'h0005, 96'h0});
    rchk(8'h08, 32'h0000_0002);
    // bounce walk: 5 ticks high, 2 low, then high again
    i_host.cmd(OP_INPUT_DEBOUNCE, {16'h0001, 16'h0008, 96'h0});
    din <= 7'h01;
    idle(5 * TC);
    din <= 7'h00;
    idle(2 * TC);
    din <= 7'h01;
    idle(4 * TC);
    chk("not yet", 32'h0000_0000, filt[0]);
    idle(2 * TC + 4);
    chk("qualified", 32'h0000_0001, filt[0]);
    // direction both ways, then refused once closed
    i_host.cmd(OP_DIRECTION, {16'h0001, 112'h0});
    idle(2);
    chk("dir ccw", 32'h0000_0001, dir);
    i_host.cmd(OP_DIRECTION, 128'h0);
    idle(2);
    chk("dir cw", 32'h0000_0000, dir);
    wr(8'h08, 32'h0000_000F);
    i_host.cmd(OP_DIRECTION, {16'h0002, 112'h0});
    wr(8'h00, 32'h0000_00AA);
    rchk(8'h08, 32'h0000_0002);
    chk("dir kept", 32'h0000_0000, dir);
    wr(8'h04, 32'h0000_0002);
    wr(8'h08, 32'h0000_000F);
    i_host.cmd(OP_DIRECTION, {16'h0001, 112'h0});
    idle(2);
    chk("closed", 32'h0000_0001, closed);
    chk("dir locked", 32'h0000_0000, dir);
    chk("fault", 32'h0000_0001, fault);
    rchk(8'h08, 32'h0000_0004);
    rchk(8'h10, 32'h0000_0A01);
    chk("cmd acks", 32'h0000_0008, n_ack);
    // mid-run reset reopens the lock and restores done and filter defaults
    wr(8'h04, 32'h0000_0001);
    nrst <= 1'b0;
    idle(2);
    nrst <= 1'b1;
    idle(4);
    chk("after reset", 32'h0000_0000, {done_oe, closed, fault, dir});
    rchk(8'h60, 32'h0000_0053);
    report_and_stop;
  end
endmodule
`default_nettype wire
